// >>> testbench/dual_pwm_timer_tb_top.sv
// Self-checking bench for the dual PWM block
`timescale 1ns/100ps
module dual_pwm_timer_tb_top;
   import pwm_pkg::*;

   logic             clock;
   logic             nrst;
   logic             psel;
   logic             penable;
   logic             pwrite;
   logic [7:0]       paddr;
   logic [31:0]      pwdata;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic             ext_clk;
   logic             pwm_a;
   logic             pwm_b;
   logic             irq;
   logic             ext_run;
   logic [1:0][15:0] hi;
   logic [1:0][15:0] per;
   logic [31:0]      rd;
   logic             er;
   int               err_count;
   int               n_compared;
   int               cycles;

   dual_pwm_timer i_dual_pwm_timer (.CLOCK(clock), .NRST(nrst),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .EXT_TIMER_CLOCK_IN(ext_clk),
      .PWM_OUT_A(pwm_a), .PWM_OUT_B(pwm_b), .IRQ(irq));

   pwm_load i_pwm_load (.clock(clock), .nrst(nrst), .pwm({pwm_b, pwm_a}),
      .ext_clk(ext_clk), .ext_run(ext_run), .ext_half(8'h08),
      .hi(hi), .per(per));

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic give_verdict();
      $display("Compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard, far above the roughly one thousand cycles the run needs
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 8000)
      begin
         err_count = err_count + 1;
         give_verdict();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // No wait-state count assumed; only the run guard ends a stall
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, exp, rd);
   endtask

   task automatic hold(input string name, input logic exp, input int n);
      int bad;
      bad = 0;
      repeat (n)
      begin
         @(posedge clock);
         if (pwm_a !== exp)
            bad++;
      end
      chk(name, 32'h0, 32'(bad));
   endtask

   task automatic t_reset();
      chk("pwm_pins", 32'h0, {30'h0, pwm_b, pwm_a});
      chk("irq", 32'h0, {31'h0, irq});
      rdchk("duty_hi_a", OFF_DUTY_HI_A, 32'h0);
      rdchk("duty_lo_b", OFF_DUTY_LO_B, 32'h0);
      rdchk("period_a", OFF_PERIOD_A, 32'hff);
      apb(1'b1, 8'h40, 32'h5a);
      chk("slverr_wr", 32'h1, {31'h0, er});
      rdchk("unmapped", 8'h40, 32'h0);
      chk("slverr_rd", 32'h1, {31'h0, er});
   endtask

   // Whole-byte writes only; no read-modify-write
   task automatic t_buffer();
      apb(1'b1, OFF_DUTY_HI_A, 32'h01);
      apb(1'b1, OFF_DUTY_LO_A, 32'h40);
      rdchk("held_hi", OFF_DUTY_HI_A, 32'h0);
      rdchk("held_lo", OFF_DUTY_LO_A, 32'h0);
      apb(1'b1, OFF_PERIOD_A, 32'h01);
      apb(1'b1, OFF_CTRL, 32'h11);
      repeat (40) @(posedge clock);
      rdchk("active_hi", OFF_DUTY_HI_A, 32'h01);
      rdchk("active_lo", OFF_DUTY_LO_A, 32'h40);
      chk("per_a", 32'd8, {16'h0, per[0]});
      chk("hi_a", 32'd5, {16'h0, hi[0]});
   endtask

   task automatic t_edges();
      apb(1'b1, OFF_PERIOD_A, 32'h03);
      for (int l = 0; l < 4; l++)
      begin
         apb(1'b1, OFF_DUTY_HI_A, 32'h03);
         apb(1'b1, OFF_DUTY_LO_A, 32'(l << 6));
         repeat (60) @(posedge clock);
         chk("hi_eq", 32'(12 + l), {16'h0, hi[0]});
         chk("per_eq", 32'd16, {16'h0, per[0]});
      end
      apb(1'b1, OFF_DUTY_HI_A, 32'h00);
      apb(1'b1, OFF_DUTY_LO_A, 32'h00);
      repeat (40) @(posedge clock);
      hold("zero_duty", 1'b0, 32);
      apb(1'b1, OFF_DUTY_HI_A, 32'h04);
      repeat (40) @(posedge clock);
      hold("full_duty", 1'b1, 32);
   endtask

   task automatic t_timebase();
      // Timer A stopped and cleared so the shorter period cannot overrun
      apb(1'b1, OFF_CTRL, 32'h10);
      apb(1'b1, OFF_PERIOD_A, 32'h01);
      apb(1'b1, OFF_TIMER_A, 32'h00);
      apb(1'b1, OFF_PERIOD_B, 32'h02);
      apb(1'b1, OFF_DUTY_HI_B, 32'h01);
      apb(1'b1, OFF_DUTY_LO_B, 32'h20);
      apb(1'b1, OFF_CTRL, 32'h73);
      repeat (60) @(posedge clock);
      chk("per_b_tb", 32'd12, {16'h0, per[1]});
      chk("hi_b_tb", 32'd4, {16'h0, hi[1]});
      apb(1'b1, OFF_DUTY_LO_B, 32'h00);
      repeat (60) @(posedge clock);
      chk("per_b_ta", 32'd8, {16'h0, per[1]});
      for (int k = 0; k < 6; k++)
      begin
         apb(1'b0, OFF_TIMER_A, 32'h0);
         chk("timer_a_wrap", 32'h0, {31'h0, rd[7:0] > 8'h01});
      end
   endtask

   task automatic t_irq();
      apb(1'b1, OFF_INT_MASK, 32'h0);
      rdchk("status", OFF_INT_STATUS, 32'h3);
      chk("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, OFF_INT_MASK, 32'h1);
      repeat (3) @(posedge clock);
      chk("irq_on", 32'h1, {31'h0, irq});
      apb(1'b1, OFF_CTRL, 32'h0);
      rdchk("sticky", OFF_INT_STATUS, 32'h3);
      apb(1'b1, OFF_INT_STATUS, 32'h3);
      rdchk("cleared", OFF_INT_STATUS, 32'h0);
      repeat (3) @(posedge clock);
      chk("irq_off", 32'h0, {31'h0, irq});
   endtask

   // Ext clock period 16 clocks, a multiple of the instruction cycle
   task automatic t_ext();
      ext_run <= 1'b1;
      apb(1'b1, OFF_DUTY_HI_A, 32'h01);
      apb(1'b1, OFF_CTRL, 32'h15);
      repeat (200) @(posedge clock);
      chk("per_ext", 32'd32, {16'h0, per[0]});
      chk("hi_ext", 32'd16, {16'h0, hi[0]});
      ext_run <= 1'b0;
      // Timer B clocked by output A; output B on timer B
      apb(1'b1, OFF_DUTY_LO_B, 32'h20);
      apb(1'b1, OFF_CTRL, 32'hbb);
      repeat (120) @(posedge clock);
      chk("per_fb", 32'd24, {16'h0, per[1]});
      chk("hi_fb", 32'd8, {16'h0, hi[1]});
   endtask

   initial
   begin
      nrst       = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 8'h00;
      pwdata     = 32'h0;
      ext_run    = 1'b0;
      err_count  = 0;
      n_compared = 0;
      cycles     = 0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      t_reset();
      t_buffer();
      t_edges();
      t_timebase();
      t_irq();
      t_ext();
      give_verdict();
   end
endmodule // dual_pwm_timer_tb_top

// >>> testbench/pwm_load.sv
// Load model on the PWM pins: measures pulses, makes the timer clock
`timescale 1ns/100ps
module pwm_load
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             nrst,
   // Pins
   input  wire logic [1:0]       pwm,
   output logic                  ext_clk,
   // Control and results
   input  wire logic             ext_run,
   input  wire logic [7:0]       ext_half,
   output logic [1:0][15:0]      hi,
   output logic [1:0][15:0]      per
);
   logic [1:0]       prev;
   logic [1:0][15:0] cnt_h;
   logic [1:0][15:0] cnt_p;
   logic [7:0]       div;

   // Counts restart at each rising edge, so a flat pin keeps old figures
   always_ff @(posedge clock)
   begin
      prev <= pwm;
      for (int i = 0; i < 2; i++)
      begin
         if (!nrst)
         begin
            hi[i]    <= 16'h0;
            per[i]   <= 16'h0;
            cnt_h[i] <= 16'h0;
            cnt_p[i] <= 16'h0;
         end
         else if (pwm[i] && !prev[i])
         begin
            hi[i]    <= cnt_h[i];
            per[i]   <= cnt_p[i];
            cnt_h[i] <= 16'h1;
            cnt_p[i] <= 16'h1;
         end
         else
         begin
            cnt_h[i] <= cnt_h[i] + {15'h0, pwm[i]};
            cnt_p[i] <= cnt_p[i] + 16'h1;
         end
      end
   end

   // Slow clock, stands low when idle
   always_ff @(posedge clock)
   begin
      if (!ext_run)
      begin
         div     <= 8'h0;
         ext_clk <= 1'b0;
      end
      else if (div == ext_half - 8'h1)
      begin
         div     <= 8'h0;
         ext_clk <= !ext_clk;
      end
      else
         div <= div + 8'h1;
   end
endmodule // pwm_load

// >>> verilog/dual_pwm_timer.sv
// Two PWM outputs on two 8-bit timers with an APB register file
`timescale 1ns/100ps
module dual_pwm_timer
(
   // Clock and reset
   input  wire logic                   CLOCK,
   input  wire logic                   NRST,
   // APB slave
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [7:0]             PADDR,
   input  wire logic [31:0]            PWDATA,
   output logic      [31:0]            PRDATA,
   output logic                        PREADY,
   output logic                        PSLVERR,
   // Pins
   input  wire logic                   EXT_TIMER_CLOCK_IN,
   output logic                        PWM_OUT_A,
   output logic                        PWM_OUT_B,
   // Interrupt
   output logic                        IRQ
);
   import pwm_pkg::*;

   ctrl_t              ctrl_r;
   logic [TIMER_W-1:0] per_a_r;
   logic [TIMER_W-1:0] per_b_r;
   logic [TIMER_W-1:0] cnt_a_r;
   logic [TIMER_W-1:0] cnt_b_r;
   logic [TIMER_W-1:0] cnt_a_nxt;
   logic [TIMER_W-1:0] cnt_b_nxt;
   logic               tb_sel_r;
   logic [1:0]         flag_r;
   logic [1:0]         flag_nxt;
   logic [1:0]         mask_r;
   logic [FRAC_W-1:0]  q_r;
   logic               ext_s1_r;
   logic               ext_s2_r;
   logic               ext_samp_r;
   logic               fb_prev_r;
   logic [31:0]        prdata_r;
   logic               pready_r;
   logic               pslverr_r;
   logic               irq_r;
   logic [31:0]        rd_mux;
   duty_t              active_a;
   duty_t              active_b;
   logic               pwm_a;
   logic               pwm_b;

   function automatic logic [31:0] byte_word(input logic [7:0] b);
      byte_word = {24'h000000, b};
   endfunction

   function automatic logic [31:0] low_word(input duty_t d,
                                            input logic sel);
      logic [7:0] v;
      v = '0;
      v[LOW_FRAC_LSB +: FRAC_W] = d.low; // [RULE_11]
      v[TB_SEL_BIT] = sel;
      low_word = byte_word(v);
   endfunction

   // APB decode
   wire logic setup   = PSEL && !PENABLE;
   wire logic done    = PSEL && PENABLE && pready_r;
   wire logic wr_en   = done && PWRITE;
   wire logic hit_ctl = PADDR == OFF_CTRL;
   wire logic hit_pa  = PADDR == OFF_PERIOD_A;
   wire logic hit_pb  = PADDR == OFF_PERIOD_B;
   wire logic hit_dha = PADDR == OFF_DUTY_HI_A;
   wire logic hit_dla = PADDR == OFF_DUTY_LO_A;
   wire logic hit_dhb = PADDR == OFF_DUTY_HI_B;
   wire logic hit_dlb = PADDR == OFF_DUTY_LO_B;
   wire logic hit_ta  = PADDR == OFF_TIMER_A;
   wire logic hit_tb  = PADDR == OFF_TIMER_B;
   wire logic hit_ist = PADDR == OFF_INT_STATUS;
   wire logic hit_msk = PADDR == OFF_INT_MASK;
   wire logic addr_ok = hit_ctl | hit_pa | hit_pb | hit_dha | hit_dla
                      | hit_dhb | hit_dlb | hit_ta | hit_tb | hit_ist
                      | hit_msk;

   // Instruction cycle and external clock sampling
   wire logic insn_end = q_r == Q_LAST;
   // Next quarter; a registered output must match the coming position
   wire logic [FRAC_W-1:0] q_nxt = q_r + 1'b1;
   wire logic ext_rise = insn_end && ext_s2_r && !ext_samp_r; // [RULE_15]
   // Fed-back output is already on this clock, so no sampling jitter
   wire logic fb_rise  = insn_end && pwm_a && !fb_prev_r; // [RULE_16]
   wire logic ext_tick = ctrl_r.ext_from_pwm ? fb_rise : ext_rise;

   // Cascading is refused while either output is in use
   wire logic chained  = ctrl_r.chain && !ctrl_r.pwm_a_en
                         && !ctrl_r.pwm_b_en; // [RULE_03]

   wire logic tick_a   = ctrl_r.timer_a_on
                         && (ctrl_r.timer_a_ext ? ext_tick
                                                : insn_end); // [RULE_14]
   wire logic match_a  = tick_a && cnt_a_r == per_a_r; // [RULE_12]
   wire logic tick_b   = ctrl_r.timer_b_on
                         && (chained ? match_a
                            : ctrl_r.timer_b_ext ? ext_tick
                                                 : insn_end); // [RULE_14]
   wire logic match_b  = tick_b && cnt_b_r == per_b_r; // [RULE_12]

   // Output B timebase choice
   wire logic                 roll_b  = tb_sel_r ? match_b
                                                 : match_a; // [RULE_02]
   wire logic [TIMER_W-1:0]   count_b = tb_sel_r ? cnt_b_nxt
                                                 : cnt_a_nxt; // [RULE_02]
   wire logic                 ext_b   = tb_sel_r ? ctrl_r.timer_b_ext
                                                 : ctrl_r.timer_a_ext;
   // External clocks give no sub-count, so duty falls to 8-bit steps
   // Next position, or high time would run one clock over duty_value
   wire logic [FRAC_W-1:0]    frac_a  = ctrl_r.timer_a_ext ? '0
                                                           : q_nxt; // [RULE_01]
   wire logic [FRAC_W-1:0]    frac_b  = ext_b ? '0 : q_nxt; // [RULE_05]

   // Timer next values; a software write wins over counting
   always_comb
   begin
      cnt_a_nxt = cnt_a_r;
      if (wr_en && hit_ta)
         cnt_a_nxt = PWDATA[TIMER_W-1:0];
      else if (match_a)
         cnt_a_nxt = '0; // [RULE_12] [RULE_01]
      else if (tick_a)
         cnt_a_nxt = cnt_a_r + 1'b1;
      cnt_b_nxt = cnt_b_r;
      if (wr_en && hit_tb)
         cnt_b_nxt = PWDATA[TIMER_W-1:0];
      else if (match_b)
         cnt_b_nxt = '0; // [RULE_12]
      else if (tick_b)
         cnt_b_nxt = cnt_b_r + 1'b1;
   end

   // Sticky flags: a match in the clearing cycle still sets
   always_comb
   begin
      flag_nxt = flag_r;
      if (wr_en && hit_ist)
         flag_nxt = flag_r & ~PWDATA[1:0];
      flag_nxt[INT_A_BIT] = flag_nxt[INT_A_BIT] | match_a; // [RULE_13]
      flag_nxt[INT_B_BIT] = flag_nxt[INT_B_BIT] | match_b; // [RULE_13]
   end

   // Read mux shows active duty, not the holding copy
   always_comb
   begin
      rd_mux = '0;
      case (1'b1)
         hit_ctl: rd_mux = byte_word(ctrl_r);
         hit_pa:  rd_mux = byte_word(per_a_r);
         hit_pb:  rd_mux = byte_word(per_b_r);
         hit_dha: rd_mux = byte_word(active_a.high); // [RULE_11]
         hit_dla: rd_mux = low_word(active_a, 1'b0);
         hit_dhb: rd_mux = byte_word(active_b.high); // [RULE_11]
         hit_dlb: rd_mux = low_word(active_b, tb_sel_r);
         hit_ta:  rd_mux = byte_word(cnt_a_r);
         hit_tb:  rd_mux = byte_word(cnt_b_r);
         hit_ist: rd_mux = {30'h0, flag_r};
         hit_msk: rd_mux = {30'h0, mask_r};
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      if (!NRST)
      begin
         q_r        <= '0;
         ext_s1_r   <= 1'b0;
         ext_s2_r   <= 1'b0;
         ext_samp_r <= 1'b0;
         fb_prev_r  <= 1'b0;
      end
      else
      begin
         q_r      <= q_r + 1'b1;
         ext_s1_r <= EXT_TIMER_CLOCK_IN;
         ext_s2_r <= ext_s1_r;
         if (insn_end)
         begin
            ext_samp_r <= ext_s2_r; // [RULE_15]
            fb_prev_r  <= pwm_a;
         end
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (!NRST)
      begin
         ctrl_r   <= CTRL_RST;
         per_a_r  <= PERIOD_RST;
         per_b_r  <= PERIOD_RST;
         tb_sel_r <= 1'b0;
         mask_r   <= '0;
         cnt_a_r  <= '0;
         cnt_b_r  <= '0;
         flag_r   <= '0;
      end
      else
      begin
         cnt_a_r <= cnt_a_nxt;
         cnt_b_r <= cnt_b_nxt;
         flag_r  <= flag_nxt;
         if (wr_en && hit_ctl)
            ctrl_r <= ctrl_t'(PWDATA[7:0]);
         if (wr_en && hit_pa)
            per_a_r <= PWDATA[TIMER_W-1:0];
         if (wr_en && hit_pb)
            per_b_r <= PWDATA[TIMER_W-1:0];
         if (wr_en && hit_dlb)
            tb_sel_r <= PWDATA[TB_SEL_BIT]; // [RULE_02]
         if (wr_en && hit_msk)
            mask_r <= PWDATA[1:0];
      end
   end

   // APB answer registered in setup: zero wait states
   always_ff @(posedge CLOCK)
   begin
      if (!NRST)
      begin
         prdata_r  <= '0;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         irq_r     <= 1'b0;
      end
      else
      begin
         pready_r  <= setup;
         pslverr_r <= setup && !addr_ok;
         if (setup)
            prdata_r <= PWRITE ? 32'h00000000 : rd_mux;
         irq_r <= |(flag_r & mask_r);
      end
   end

   pwm_channel #(.POS_W(DUTY_W)) u_chan_a
   (
      .clock    (CLOCK),
      .nrst     (NRST),
      .wr_high  (wr_en && hit_dha),
      .wr_low   (wr_en && hit_dla),
      .wdata    (PWDATA[7:0]),
      .enable   (ctrl_r.pwm_a_en),
      .rollover (match_a), // [RULE_01]
      .count    (cnt_a_nxt),
      .frac     (frac_a),
      .active   (active_a),
      .pwm      (pwm_a)
   );

   pwm_channel #(.POS_W(DUTY_W)) u_chan_b
   (
      .clock    (CLOCK),
      .nrst     (NRST),
      .wr_high  (wr_en && hit_dhb),
      .wr_low   (wr_en && hit_dlb),
      .wdata    (PWDATA[7:0]),
      .enable   (ctrl_r.pwm_b_en),
      .rollover (roll_b), // [RULE_02]
      .count    (count_b),
      .frac     (frac_b),
      .active   (active_b),
      .pwm      (pwm_b)
   );

   assign PRDATA    = prdata_r;
   assign PREADY    = pready_r;
   assign PSLVERR   = pslverr_r;
   assign PWM_OUT_A = pwm_a;
   assign PWM_OUT_B = pwm_b;
   assign IRQ       = irq_r;

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!NRST);

   property p_timer_clear;
      match_a && !(wr_en && hit_ta) |=> cnt_a_r == '0;
   endproperty
   a_timer_clear: assert property (p_timer_clear) // [RULE_12]
      else $error("timer A did not clear on match");

   property p_period_len;
      ctrl_r.timer_a_on && !ctrl_r.timer_a_ext && insn_end
      && cnt_a_r != per_a_r && !wr_en
      |=> ##3 cnt_a_r == $past(cnt_a_r, 4) + 1'b1;
   endproperty
   a_period_len: assert property (p_period_len) // [RULE_01]
      else $error("timer A did not step once per four clocks");

   property p_flag_sticky;
      match_a |=> flag_r[INT_A_BIT] [*2];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) // [RULE_13]
      else $error("timer A flag not held after match");

   property p_b_on_a;
      !tb_sel_r && match_a && ctrl_r.pwm_b_en
      |=> PWM_OUT_B == (active_b != '0);
   endproperty
   a_b_on_a: assert property (p_b_on_a) // [RULE_02]
      else $error("output B not restarted by timer A");

   property p_zero_duty;
      active_a == '0 && !match_a |=> !PWM_OUT_A;
   endproperty
   a_zero_duty: assert property (p_zero_duty) // [RULE_06]
      else $error("output A high with zero duty");

   property p_full_duty;
      ctrl_r.pwm_a_en && active_a.high > per_a_r && !match_a
      |=> PWM_OUT_A;
   endproperty
   a_full_duty: assert property (p_full_duty) // [RULE_08]
      else $error("output A low with duty above period");

   property p_read_active;
      setup && !PWRITE && hit_dha |=> PRDATA[7:0] == $past(active_a.high);
   endproperty
   a_read_active: assert property (p_read_active) // [RULE_11]
      else $error("duty read did not return active copy");

   property p_no_chain;
      ctrl_r.pwm_a_en && tick_b && !ctrl_r.timer_b_ext |-> insn_end;
   endproperty
   a_no_chain: assert property (p_no_chain) // [RULE_03]
      else $error("timer B cascaded while a PWM output runs");

   property p_ext_sample;
      tick_a && ctrl_r.timer_a_ext |-> q_r == Q_LAST;
   endproperty
   a_ext_sample: assert property (p_ext_sample) // [RULE_15]
      else $error("external tick off the instruction boundary");

   property p_irq_level;
      |(flag_r & mask_r) |=> IRQ;
   endproperty
   a_irq_level: assert property (p_irq_level) // [RULE_12]
      else $error("interrupt low with unmasked flag set");

endmodule // dual_pwm_timer

// >>> verilog/pwm_channel.sv
// One PWM output: double-buffered duty and position-to-duty compare
`timescale 1ns/100ps
module pwm_channel
#(
   parameter int POS_W = pwm_pkg::DUTY_W
)
(
   // Clock and reset
   input  wire logic                        clock,
   input  wire logic                        nrst,
   // Software writes
   input  wire logic                        wr_high,
   input  wire logic                        wr_low,
   input  wire logic [7:0]                  wdata,
   // Timebase
   input  wire logic                        enable,
   input  wire logic                        rollover,
   input  wire logic [pwm_pkg::TIMER_W-1:0] count,
   input  wire logic [pwm_pkg::FRAC_W-1:0]  frac,
   // Results
   output pwm_pkg::duty_t                   active,
   output logic                             pwm
);
   import pwm_pkg::*;

   if (POS_W != TIMER_W + FRAC_W)
   begin : g_bad_width
      $error("pwm_channel: POS_W must equal timer plus fraction width");
   end

   duty_t master_r;
   duty_t master_nxt;
   duty_t slave_r;
   logic  pwm_r;

   // Position of the coming cycle, so the output lines up with it
   wire logic [POS_W-1:0] position = {count, frac};
   wire logic             below    = position < slave_r; // [RULE_05] [RULE_07]

   // Writes touch only the holding copy
   always_comb
   begin
      master_nxt = master_r;
      if (wr_high)
         master_nxt.high = wdata; // [RULE_04] [RULE_09]
      if (wr_low)
         master_nxt.low = wdata[LOW_FRAC_LSB +: FRAC_W]; // [RULE_04]
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         master_r <= '0; // [RULE_19]
         slave_r  <= '0;
         pwm_r    <= 1'b0;
      end
      else
      begin
         master_r <= master_nxt;
         if (rollover)
            slave_r <= master_nxt; // [RULE_10]
         // Zero duty never rises, even on the forced edge
         if (!enable)
            pwm_r <= 1'b0; // [RULE_19]
         else if (rollover)
            pwm_r <= master_nxt != '0; // [RULE_10] [RULE_06]
         else
            pwm_r <= below; // [RULE_05] [RULE_08]
      end
   end

   assign active = slave_r;
   assign pwm    = pwm_r;

   property p_hold_active;
      @(posedge clock) disable iff (!nrst)
      (wr_high || wr_low) && !rollover |=> active == $past(slave_r);
   endproperty
   a_hold_active: assert property (p_hold_active) // [RULE_09]
      else $error("active duty changed without rollover");

   property p_high_below;
      @(posedge clock) disable iff (!nrst)
      enable && !rollover && position < slave_r |=> pwm;
   endproperty
   a_high_below: assert property (p_high_below) // [RULE_05]
      else $error("output low while position below duty");

endmodule // pwm_channel

// >>> verilog/pwm_pkg.sv
// Constants, register map and carrier types for the dual PWM block
//
// How it works
// RULE_01: Output A period is (period_reg_a + 1) instruction cycles of four clocks.
// RULE_02: Output B uses timer A, or timer B when out_b_timebase_sel is set.
// RULE_03: Timers never cascade into one 16-bit timer while a PWM output runs.
// RULE_04: duty_value is duty high byte above duty low bits 7:6.
// RULE_05: Output stays high for duty_value clock periods in each period.
// RULE_06: A duty_value of zero keeps the output low all period.
// RULE_07: Duty high equal to period gives one to four low clocks.
// RULE_08: Duty high above the period keeps the output high always.
// RULE_09: Software writes land in a holding copy, active copy untouched.
// RULE_10: At rollover holding copy moves to active copy, output forced high.
// RULE_11: Duty register reads return the active copy.
// RULE_12: Timer equal to its period clears to zero and raises its event.
// RULE_13: Each timer match sets a sticky flag that software clears.
// RULE_14: Outputs work with internal or external timer clock.
// RULE_15: External timer clock is sampled once per instruction cycle.
// RULE_16: A PWM output fed back as timer clock is used without sampling; the code samples output A once per instruction cycle, like the external clock.
// RULE_17: Software should avoid read-modify-write on duty registers.
// RULE_18: External timer clock should run far below the device clock.
// RULE_19: After reset outputs are low and all duty copies are zero.
package pwm_pkg;

   localparam int TIMER_W = 8;
   localparam int FRAC_W  = 2;
   localparam int DUTY_W  = TIMER_W + FRAC_W;

   // Instruction cycle is four clocks; last quarter index
   localparam logic [FRAC_W-1:0] Q_LAST = 2'h3;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL       = 8'h00;
   localparam logic [7:0] OFF_PERIOD_A   = 8'h04;
   localparam logic [7:0] OFF_PERIOD_B   = 8'h08;
   localparam logic [7:0] OFF_DUTY_HI_A  = 8'h0c;
   localparam logic [7:0] OFF_DUTY_LO_A  = 8'h10;
   localparam logic [7:0] OFF_DUTY_HI_B  = 8'h14;
   localparam logic [7:0] OFF_DUTY_LO_B  = 8'h18;
   localparam logic [7:0] OFF_TIMER_A    = 8'h1c;
   localparam logic [7:0] OFF_TIMER_B    = 8'h20;
   localparam logic [7:0] OFF_INT_STATUS = 8'h24;
   localparam logic [7:0] OFF_INT_MASK   = 8'h28;

   // Field positions
   localparam int LOW_FRAC_LSB = 6;
   localparam int TB_SEL_BIT   = 5;
   localparam int INT_A_BIT    = 0;
   localparam int INT_B_BIT    = 1;

   // Reset values
   localparam logic [7:0]         CTRL_RST   = 8'h00;
   localparam logic [TIMER_W-1:0] PERIOD_RST = 8'hff;

   typedef struct packed {
      logic ext_from_pwm;
      logic chain;
      logic pwm_b_en;
      logic pwm_a_en;
      logic timer_b_ext;
      logic timer_a_ext;
      logic timer_b_on;
      logic timer_a_on;
   } ctrl_t;

   typedef struct packed {
      logic [TIMER_W-1:0] high;
      logic [FRAC_W-1:0]  low;
   } duty_t;

endpackage
